// ### common/aoi_pkg.sv
// package of constants for the area-of-interest width and starting line commands
// assumes frames arrive already parsed by the framing layer, one command per handshake
package aoi_pkg;

   // ------------------------------------------------------------
   // command codes and frame fields
   // ------------------------------------------------------------
   localparam logic [7:0] AOI_CODE_WIDTH = 8'hab; // region width in columns
   localparam logic [7:0] AOI_CODE_LINE = 8'ha8; // region starting line
   localparam logic AOI_FLAG_READ = 1'b1;
   localparam logic AOI_FLAG_WRITE = 1'b0;
   localparam logic [7:0] AOI_VALUE_LEN = 8'h02; // every frame here carries two value bytes

   // ------------------------------------------------------------
   // value ranges, offsets and reset values
   // ------------------------------------------------------------
   localparam logic [15:0] AOI_WIDTH_MIN = 16'h0001;
   localparam logic [15:0] AOI_WIDTH_MAX = 16'h0570;
   localparam logic [15:0] AOI_LINE_MIN = 16'h0000;
   localparam logic [15:0] AOI_LINE_MAX = 16'h040f;
   localparam logic [15:0] AOI_LINE_OFFSET = 16'h0001; // sensor line = programmed value + 1
   localparam logic [15:0] AOI_WIDTH_RST = 16'h0570; // full width out of reset
   localparam logic [15:0] AOI_LINE_RST = 16'h0000; // first sensor line out of reset

   // ------------------------------------------------------------
   // control states, one-hot
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      AOI_ST_IDLE = 2'b01,
      AOI_ST_REPLY = 2'b10
   } aoi_state_type;

endpackage : aoi_pkg

// ### rtl/aoi_cmd.sv
// command interpreter for the area-of-interest width and starting line settings
// assumes a framing layer that hands over whole parsed frames and takes replies
// with a valid/ready handshake, all on sys_clk

// Notes on behaviour
// - a width read (code 0xab, flag 1, length 2, no data) is answered with code 0xab, flag 0, length 2 and two bytes.
// - a width write (code 0xab, flag 0, length 2, two bytes) is carried out and gets no reply.
// - the width value travels low byte first and high byte second, in writes and in replies.
// - width values from 1 through 1392 columns are accepted.
// - the starting line uses code 0xa8 with the same read, reply and silent write frame shapes.
// - the starting line value travels low byte first and high byte second in both directions.
// - starting line values from 0 through 1039 are accepted.
// - a programmed starting line n places the region at sensor line n plus 1.
module aoi_cmd #(
   parameter logic [15:0] WIDTH_MAX = aoi_pkg::AOI_WIDTH_MAX,
   parameter logic [15:0] LINE_MAX = aoi_pkg::AOI_LINE_MAX
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [7:0] command_code,
   input wire logic cmd_rw_flag,
   input wire logic [7:0] cmd_length,
   input wire logic [7:0] cmd_byte1,
   input wire logic [7:0] cmd_byte2,
   output logic rsp_valid,
   input wire logic rsp_ready,
   output logic [7:0] rsp_code,
   output logic rsp_rw_flag,
   output logic [7:0] rsp_length,
   output logic [7:0] rsp_byte1,
   output logic [7:0] rsp_byte2,
   output logic cmd_done,
   output logic cmd_reject,
   output logic [15:0] aoi_width,
   output logic [15:0] aoi_line_setting,
   output logic [15:0] aoi_first_line
);
   import aoi_pkg::*;

   // ------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------
   if (WIDTH_MAX < AOI_WIDTH_MIN || WIDTH_MAX < AOI_WIDTH_RST) begin : g_bad_width
      $error("WIDTH_MAX below the minimum or the reset width");
   end
   if (LINE_MAX == 16'hffff) begin : g_bad_line
      $error("LINE_MAX leaves no room for the line offset");
   end

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      aoi_state_type state;
      logic [15:0] width;
      logic [15:0] line;
      logic [15:0] first_line;
      logic [7:0] rsp_code;
      logic [7:0] rsp_b1;
      logic [7:0] rsp_b2;
      logic done;
      logic reject;
   } aoi_regs_type;

   aoi_regs_type r_q;
   aoi_regs_type r_d;

   logic cmd_fire;
   logic frame_ok;
   logic is_width;
   logic is_line;
   logic is_read;
   logic [15:0] wr_value;
   logic width_in_range;
   logic line_in_range;

   // range test shared by both settings
   function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
      in_range = (v >= lo) && (v <= hi);
   endfunction : in_range

   // ------------------------------------------------------------
   // request decode
   // ------------------------------------------------------------
   assign cmd_ready = r_q.state == AOI_ST_IDLE; // one reply outstanding at most
   assign cmd_fire = cmd_valid && cmd_ready;
   assign is_width = command_code == AOI_CODE_WIDTH;
   assign is_line = command_code == AOI_CODE_LINE;
   assign is_read = cmd_rw_flag == AOI_FLAG_READ;
   assign frame_ok = (is_width || is_line) && cmd_length == AOI_VALUE_LEN;
   assign wr_value = {cmd_byte2, cmd_byte1};
   assign width_in_range = in_range(wr_value, AOI_WIDTH_MIN, WIDTH_MAX);
   assign line_in_range = in_range(wr_value, AOI_LINE_MIN, LINE_MAX);

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      r_d = r_q;
      r_d.done = 1'b0;
      r_d.reject = 1'b0;
      r_d.first_line = 16'(r_q.line + AOI_LINE_OFFSET);
      unique case (r_q.state)
         AOI_ST_IDLE: begin
            if (cmd_fire) begin
               if (!frame_ok) begin
                  r_d.reject = 1'b1;
               end else if (is_read) begin
                  // load reply, low byte first
                  r_d.state = AOI_ST_REPLY;
                  r_d.rsp_code = command_code;
                  r_d.rsp_b1 = is_width ? r_q.width[7:0] : r_q.line[7:0];
                  r_d.rsp_b2 = is_width ? r_q.width[15:8] : r_q.line[15:8];
                  r_d.done = 1'b1;
               end else if (is_width && width_in_range) begin
                  r_d.width = wr_value;
                  r_d.done = 1'b1;
               end else if (is_line && line_in_range) begin
                  r_d.line = wr_value;
                  r_d.done = 1'b1;
               end else begin
                  r_d.reject = 1'b1;
               end
            end
         end
         AOI_ST_REPLY: begin
            if (rsp_ready) begin
               r_d.state = AOI_ST_IDLE;
            end
         end
         default: begin
            r_d.state = AOI_ST_IDLE;
         end
      endcase
   end

   // state register, synchronous reset
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         r_q <= '{state: AOI_ST_IDLE, width: AOI_WIDTH_RST, line: AOI_LINE_RST,
                  first_line: 16'(AOI_LINE_RST + AOI_LINE_OFFSET), rsp_code: 8'h00,
                  rsp_b1: 8'h00, rsp_b2: 8'h00, done: 1'b0, reject: 1'b0};
      end else begin
         r_q <= r_d;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign rsp_valid = r_q.state == AOI_ST_REPLY;
   assign rsp_code = r_q.rsp_code;
   assign rsp_rw_flag = AOI_FLAG_WRITE; // replies carry flag 0
   assign rsp_length = AOI_VALUE_LEN;
   assign rsp_byte1 = r_q.rsp_b1;
   assign rsp_byte2 = r_q.rsp_b2;
   assign cmd_done = r_q.done;
   assign cmd_reject = r_q.reject;
   assign aoi_width = r_q.width;
   assign aoi_line_setting = r_q.line;
   assign aoi_first_line = r_q.first_line;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   sequence s_good_read;
      cmd_fire && frame_ok && is_read;
   endsequence
   sequence s_width_write;
      cmd_fire && frame_ok && !is_read && is_width;
   endsequence
   sequence s_line_write;
      cmd_fire && frame_ok && !is_read && is_line;
   endsequence
   sequence s_bad_frame;
      cmd_fire && !frame_ok;
   endsequence

   a_read_reply: assert property (s_good_read |=> rsp_valid && rsp_code == $past(command_code)
      && rsp_rw_flag == AOI_FLAG_WRITE && rsp_length == AOI_VALUE_LEN) else $error("read got no proper reply");
   a_write_silent: assert property ((s_width_write or s_line_write) |=> !rsp_valid)
      else $error("write produced a reply");
   a_width_bytes: assert property (s_good_read ##0 is_width |=>
      rsp_byte1 == aoi_width[7:0] && rsp_byte2 == aoi_width[15:8]) else $error("width reply byte order wrong");
   a_line_bytes: assert property (s_good_read ##0 is_line |=>
      {rsp_byte2, rsp_byte1} == aoi_line_setting) else $error("line reply byte order wrong");
   a_width_store: assert property (s_width_write ##0 width_in_range |=>
      aoi_width == $past(wr_value) && cmd_done) else $error("valid width not stored");
   a_line_store: assert property (s_line_write ##0 line_in_range |=>
      aoi_line_setting == $past(wr_value) && cmd_done) else $error("valid line not stored");
   a_keep_bad: assert property (((s_width_write ##0 !width_in_range) or (s_line_write ##0 !line_in_range)) |=>
      $stable(aoi_width) && $stable(aoi_line_setting) && cmd_reject) else $error("bad value changed a setting");
   a_line_offset: assert property (##1 1'b1 |-> aoi_first_line == $past(aoi_line_setting) + AOI_LINE_OFFSET)
      else $error("first line not setting plus one");
   a_reply_hold: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_code)
      && $stable(rsp_byte1) && $stable(rsp_byte2)) else $error("reply dropped before taken");
   a_width_range: assert property (aoi_width >= AOI_WIDTH_MIN && aoi_width <= WIDTH_MAX)
      else $error("width outside range");

   // further guards on the handshake, the ranges and the line offset
   a_line_range: assert property (aoi_line_setting <= LINE_MAX)
      else $error("line setting outside range");
   a_reply_release: assert property (rsp_valid && rsp_ready |=> !rsp_valid && cmd_ready)
      else $error("reply not released after take");
   a_read_waits: assert property (rsp_valid && !rsp_ready |=> !cmd_done && !cmd_reject)
      else $error("command acted on while reply pending");
   a_idle_quiet: assert property (!cmd_fire |=> !cmd_done && !cmd_reject)
      else $error("status pulse without a command");
   a_bad_frame: assert property (s_bad_frame |=> cmd_reject && !cmd_done && !rsp_valid
      && $stable(aoi_width) && $stable(aoi_line_setting)) else $error("bad frame was acted on");
   // sensor line follows a stored write two edges later
   a_line_first: assert property (s_line_write ##0 line_in_range |-> ##2
      aoi_first_line == $past(wr_value, 2) + AOI_LINE_OFFSET) else $error("first line not written value plus one");

endmodule : aoi_cmd

// ### dv/aoi_host_model.sv
// host side model: takes reply frames from the command interpreter
// assumes one sys_clk domain and a stall input driven by the bench
module aoi_host_model (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic stall,
   input wire logic rsp_valid,
   output logic rsp_ready
);
   // one-cycle take strobe, held back while stalled
   always_ff @(posedge sys_clk) begin
      if (!rst_b) rsp_ready <= 1'b0;
      else rsp_ready <= rsp_valid && !stall && !rsp_ready;
   end
endmodule : aoi_host_model

// ### dv/tb.sv
// self-checking bench for the width and starting line command interpreter
// assumes aoi_pkg and aoi_host_model are compiled first
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import aoi_pkg::*;
   logic sys_clk = 0, rst_b = 0, cmd_valid = 0, cmd_rw_flag = 0, stall = 0;
   logic [7:0] command_code = 8'h00, cmd_length = 8'h00, cmd_byte1 = 8'h00, cmd_byte2 = 8'h00;
   logic cmd_ready, rsp_valid, rsp_ready, rsp_rw_flag, cmd_done, cmd_reject;
   logic [7:0] rsp_code, rsp_length, rsp_byte1, rsp_byte2;
   logic [15:0] aoi_width, aoi_line_setting, aoi_first_line;
   int n_fail = 0, check_count = 0;
   aoi_cmd aoi_cmd_i (.sys_clk, .rst_b, .cmd_valid, .cmd_ready, .command_code, .cmd_rw_flag, .cmd_length,
      .cmd_byte1, .cmd_byte2, .rsp_valid, .rsp_ready, .rsp_code, .rsp_rw_flag, .rsp_length, .rsp_byte1,
      .rsp_byte2, .cmd_done, .cmd_reject, .aoi_width, .aoi_line_setting, .aoi_first_line);
   aoi_host_model aoi_host_model_i (.sys_clk, .rst_b, .stall, .rsp_valid, .rsp_ready);
   // 4 ns clock
   initial forever #2 sys_clk = ~sys_clk;
   // compare and count
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : give_verdict
   // offer one frame, wait for the take, judge the outcome half a cycle later
   task automatic xfer(input logic [7:0] code, input logic rw, input logic [7:0] len,
      input logic [15:0] val, input logic rej);
      int i;
      @(posedge sys_clk);
      cmd_valid <= 1'b1;
      command_code <= code;
      cmd_rw_flag <= rw;
      cmd_length <= len;
      {cmd_byte2, cmd_byte1} <= val;
      for (i = 0; i < 50; i++) begin
         @(negedge sys_clk);
         if (cmd_ready === 1'b1) break;
      end
      if (i == 50) begin
         n_fail++;
         $display("[FAIL] %0t ready timeout", $time);
         give_verdict();
      end
      @(posedge sys_clk);
      cmd_valid <= 1'b0;
      @(negedge sys_clk);
      chk(16'(cmd_reject), 16'(rej));
      chk(16'(cmd_done), 16'(!rej));
      chk(16'(rsp_valid), 16'(rw && !rej));
      if (rw && !rej) begin
         chk(16'(rsp_code), 16'(code));
         chk(16'(rsp_rw_flag), 16'h0000);
         chk(16'(rsp_length), 16'h0002);
         chk({rsp_byte2, rsp_byte1}, val);
      end
   endtask : xfer
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      chk(aoi_width, 16'h0570);
      chk(aoi_line_setting, 16'h0000);
      chk(aoi_first_line, 16'h0001);
      chk(16'(cmd_ready), 16'h0001);
      $display("t_reset done");
   endtask : t_reset
   task automatic t_width();
      xfer(AOI_CODE_WIDTH, 1'b0, 8'h02, 16'h0210, 1'b0);
      chk(aoi_width, 16'h0210);
      xfer(AOI_CODE_WIDTH, 1'b1, 8'h02, 16'h0210, 1'b0);
      xfer(AOI_CODE_WIDTH, 1'b0, 8'h02, 16'h0000, 1'b1);
      xfer(AOI_CODE_WIDTH, 1'b0, 8'h02, 16'h0571, 1'b1);
      chk(aoi_width, 16'h0210);
      xfer(AOI_CODE_WIDTH, 1'b0, 8'h02, 16'h0001, 1'b0);
      chk(aoi_width, 16'h0001);
      xfer(AOI_CODE_WIDTH, 1'b0, 8'h02, 16'h0570, 1'b0);
      chk(aoi_width, 16'h0570);
      xfer(AOI_CODE_WIDTH, 1'b1, 8'h01, 16'h0000, 1'b1);
      $display("t_width done");
   endtask : t_width
   task automatic t_line();
      xfer(AOI_CODE_LINE, 1'b0, 8'h02, 16'h040f, 1'b0);
      @(negedge sys_clk);
      chk(aoi_first_line, 16'h0410);
      @(posedge sys_clk);
      stall <= 1'b1;
      xfer(AOI_CODE_LINE, 1'b1, 8'h02, 16'h040f, 1'b0);
      repeat (4) @(negedge sys_clk);
      chk(16'(rsp_valid), 16'h0001);
      @(posedge sys_clk);
      stall <= 1'b0;
      xfer(AOI_CODE_LINE, 1'b0, 8'h02, 16'h0410, 1'b1);
      chk(aoi_line_setting, 16'h040f);
      xfer(AOI_CODE_LINE, 1'b0, 8'h02, 16'h0000, 1'b0);
      @(negedge sys_clk);
      chk(aoi_first_line, 16'h0001);
      xfer(8'ha9, 1'b0, 8'h02, 16'h0005, 1'b1);
      xfer(AOI_CODE_LINE, 1'b0, 8'h03, 16'h0005, 1'b1);
      chk(aoi_line_setting, 16'h0000);
      $display("t_line done");
   endtask : t_line
   // reset in mid-run, then a read offered at the first edge after release and taken at the second
   task automatic t_rerun();
      xfer(AOI_CODE_WIDTH, 1'b0, 8'h02, 16'h0100, 1'b0);
      @(posedge sys_clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(negedge sys_clk);
      chk(aoi_width, 16'h0570);
      chk(aoi_first_line, 16'h0001);
      xfer(AOI_CODE_WIDTH, 1'b1, 8'h02, 16'h0570, 1'b0);
      $display("t_rerun done");
   endtask : t_rerun
   // reset for 8 cycles, then the scenarios
   initial begin
      repeat (8) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(negedge sys_clk);
      t_reset();
      t_width();
      t_line();
      t_rerun();
      give_verdict();
   end
endmodule : tb
